/* File: rtl/pec_pkg.sv */
// shared constants and types of the pulse event counter and capture unit
package pec_pkg;

  localparam int          WB_AW         = 8;
  localparam int          WB_DW         = 32;
  localparam int          CNT_W         = 8;
  localparam int          PRESC_W       = 7;

  // register byte offsets
  localparam logic [7:0]  OFS_CTRL      = 8'h00;
  localparam logic [7:0]  OFS_REG_A     = 8'h04;
  localparam logic [7:0]  OFS_REG_B     = 8'h08;
  localparam logic [7:0]  OFS_STATUS    = 8'h0c;

  // timer_control_reg field positions
  localparam int          CTRL_RUN_BIT  = 0;
  localparam int          CTRL_MODE_BIT = 1;
  localparam int          CTRL_AUTOCAP_BIT = 2;
  localparam int          CTRL_SEL_LSB  = 4;
  localparam int          CTRL_SEL_MSB  = 6;

  // status field positions
  localparam int          STAT_SUSP_BIT = 8;
  localparam int          STAT_ZERO_BIT = 9;

  // values after reset, and the counter maximum
  localparam logic [7:0]  RST_REG_A     = 8'hff;
  localparam logic [7:0]  RST_REG_B     = 8'hff;
  localparam logic [7:0]  RST_CNT       = 8'h00;
  localparam logic [7:0]  CNT_MAX       = 8'hff;
  localparam logic [2:0]  RST_SEL       = 3'h0;

  typedef enum logic {
    PEC_MODE_EVENT   = 1'b0,
    PEC_MODE_CAPTURE = 1'b1
  } pec_mode_t;

endpackage

/* File: rtl/pec_edge_sync.sv */
// two-flop synchroniser with rising and falling edge detection
`timescale 1ns/1ps
module pec_edge_sync (
  input  wire logic clk_in,
  input  wire logic arst_n_in,
  input  wire logic pin_in,
  output logic      rise_out,
  output logic      fall_out
);

  typedef struct packed {
    logic meta;
    logic sync;
    logic prev;
  } pec_sync_t;

  pec_sync_t s_r;
  pec_sync_t s_nxt;

  always_comb begin
    s_nxt      = s_r;
    s_nxt.meta = pin_in;
    s_nxt.sync = s_r.meta;
    s_nxt.prev = s_r.sync;
  end

  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  // only the second and third stages feed the detectors
  assign rise_out = s_r.sync & ~s_r.prev;
  assign fall_out = ~s_r.sync & s_r.prev;

endmodule

/* File: rtl/pec_top.sv */
// pulse event counter and capture unit with a classic wishbone slave
//
// The register offsets and the Wishbone slave port were chosen for this implementation.
`timescale 1ns/1ps
module pec_top (
  input  wire logic                        CLK_SYS_IN,
  input  wire logic                        ARST_N_IN,
  input  wire logic                        WB_CYC_IN,
  input  wire logic                        WB_STB_IN,
  input  wire logic                        WB_WE_IN,
  input  wire logic [pec_pkg::WB_AW-1:0]   WB_ADR_IN,
  input  wire logic [3:0]                  WB_SEL_IN,
  input  wire logic [pec_pkg::WB_DW-1:0]   WB_DAT_IN,
  output logic      [pec_pkg::WB_DW-1:0]   WB_DAT_OUT,
  output logic                             WB_ACK_OUT,
  input  wire logic                        EVENT_INPUT_PIN_IN,
  input  wire logic                        STOP_ENTRY_IN,
  output logic                             TIMER_IRQ_OUT
);
  import pec_pkg::*;

  typedef struct packed {
    logic                 run;
    pec_mode_t            mode;
    logic                 auto_capture_enable;
    logic [2:0]           sel;
    logic [CNT_W-1:0]     cnt;
    logic [CNT_W-1:0]     reg_a;
    logic [CNT_W-1:0]     reg_b;
    logic                 zero_hold;
    logic                 susp;
    logic [PRESC_W-1:0]   presc;
    logic                 irq;
    logic                 ack;
    logic [WB_DW-1:0]     dat;
  } pec_state_t;

  pec_state_t s_r;
  pec_state_t s_nxt;

  logic               pin_rise;
  logic               pin_fall;
  logic               stop_meta_r;
  logic               stop_sync_r;
  logic               req;
  logic               wr_ctrl;
  logic               wr_a;
  logic               rd_a;
  logic               tick;
  logic [PRESC_W-1:0] tick_mask;
  logic               ev_match;
  logic               cap_ovf;

  pec_edge_sync u_pin_sync (
    .clk_in    (CLK_SYS_IN),
    .arst_n_in (ARST_N_IN),
    .pin_in    (EVENT_INPUT_PIN_IN),
    .rise_out  (pin_rise),
    .fall_out  (pin_fall)
  );

  // stop entry comes from outside this clock, so it is synchronised too
  always_ff @(posedge CLK_SYS_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      stop_meta_r <= 1'b0;
      stop_sync_r <= 1'b0;
    end else begin
      stop_meta_r <= STOP_ENTRY_IN;
      stop_sync_r <= stop_meta_r;
    end
  end

  // each request is taken once, in the cycle before ack rises
  assign req     = WB_CYC_IN & WB_STB_IN & ~s_r.ack;
  assign wr_ctrl = req & WB_WE_IN & WB_SEL_IN[0] & (WB_ADR_IN == OFS_CTRL);
  assign wr_a    = req & WB_WE_IN & WB_SEL_IN[0] & (WB_ADR_IN == OFS_REG_A);
  assign rd_a    = req & ~WB_WE_IN & (WB_ADR_IN == OFS_REG_A);

  // capture source clock: one tick every 2**sel system cycles
  assign tick_mask = PRESC_W'((8'h01 << s_r.sel) - 8'h01);
  assign tick      = (s_r.presc & tick_mask) == tick_mask;

  assign ev_match = s_r.run & (s_r.mode == PEC_MODE_EVENT) & pin_fall
                    & (s_r.cnt == s_r.reg_a);
  assign cap_ovf  = s_r.run & (s_r.mode == PEC_MODE_CAPTURE) & tick & ~s_r.susp
                    & ~pin_rise & (s_r.cnt == CNT_MAX);

  always_comb begin
    s_nxt       = s_r;
    s_nxt.irq   = 1'b0;
    s_nxt.presc = s_r.presc + PRESC_W'(1);

    if (s_r.run && s_r.mode == PEC_MODE_EVENT) begin
      if (pin_rise) begin
        s_nxt.cnt       = s_r.cnt + CNT_W'(1);
        s_nxt.zero_hold = 1'b0;
      end
      if (ev_match) begin
        // match is judged at the falling edge only
        s_nxt.irq       = 1'b1;
        s_nxt.cnt       = RST_CNT;
        s_nxt.zero_hold = 1'b1;
      end
      // the zero left by a match stays out of reg b
      if (s_r.auto_capture_enable && !s_r.zero_hold) begin
        s_nxt.reg_b = s_r.cnt;
      end
    end else if (s_r.run && s_r.mode == PEC_MODE_CAPTURE) begin
      // auto-capture has no effect here
      if (tick) begin
        s_nxt.cnt = s_r.cnt + CNT_W'(1);
      end
      if (!s_r.susp) begin
        if (pin_fall) begin
          s_nxt.reg_b = s_r.cnt;
        end
        if (pin_rise) begin
          // reg b untouched on a rising edge, so a first rise captures only a
          s_nxt.reg_a = s_r.cnt;
          s_nxt.irq   = 1'b1;
          s_nxt.cnt   = RST_CNT;
        end else if (cap_ovf) begin
          s_nxt.reg_a = CNT_MAX;
          s_nxt.irq   = 1'b1;
          s_nxt.cnt   = RST_CNT;
          s_nxt.susp  = 1'b1;
        end
      end
    end

    // hardware captures outrank a software write of reg a in the same cycle
    if (wr_a && !(s_r.run && s_r.mode == PEC_MODE_CAPTURE && !s_r.susp
                  && (pin_rise || cap_ovf))) begin
      s_nxt.reg_a = WB_DAT_IN[CNT_W-1:0];
    end
    if (rd_a && !cap_ovf) begin
      s_nxt.susp = 1'b0;
    end

    if (wr_ctrl) begin
      s_nxt.run  = WB_DAT_IN[CTRL_RUN_BIT];
      s_nxt.mode = pec_mode_t'(WB_DAT_IN[CTRL_MODE_BIT]);
      s_nxt.auto_capture_enable = WB_DAT_IN[CTRL_AUTOCAP_BIT];
      s_nxt.sel  = WB_DAT_IN[CTRL_SEL_MSB:CTRL_SEL_LSB];
    end
    if (stop_sync_r) begin
      s_nxt.run = 1'b0;
    end
    // a stopped counter is held at zero and capture restarts clean
    if (!s_nxt.run) begin
      s_nxt.cnt       = RST_CNT;
      s_nxt.zero_hold = 1'b0;
      s_nxt.susp      = 1'b0;
    end

    s_nxt.ack = req;
    s_nxt.dat = '0;
    if (req && !WB_WE_IN) begin
      case (WB_ADR_IN)
        OFS_CTRL: begin
          s_nxt.dat[CTRL_RUN_BIT]              = s_r.run;
          s_nxt.dat[CTRL_MODE_BIT]             = s_r.mode;
          s_nxt.dat[CTRL_AUTOCAP_BIT]          = s_r.auto_capture_enable;
          s_nxt.dat[CTRL_SEL_MSB:CTRL_SEL_LSB] = s_r.sel;
        end
        OFS_REG_A: begin
          s_nxt.dat[CNT_W-1:0] = s_r.reg_a;
        end
        OFS_REG_B: begin
          s_nxt.dat[CNT_W-1:0] = s_r.reg_b;
        end
        OFS_STATUS: begin
          s_nxt.dat[CNT_W-1:0]     = s_r.cnt;
          s_nxt.dat[STAT_SUSP_BIT] = s_r.susp;
          s_nxt.dat[STAT_ZERO_BIT] = s_r.zero_hold;
        end
        default: begin
          s_nxt.dat = '0;
        end
      endcase
    end
  end

  always_ff @(posedge CLK_SYS_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      s_r       <= '0;
      s_r.mode  <= PEC_MODE_EVENT;
      s_r.sel   <= RST_SEL;
      s_r.cnt   <= RST_CNT;
      s_r.reg_a <= RST_REG_A;
      s_r.reg_b <= RST_REG_B;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign WB_DAT_OUT    = s_r.dat;
  assign WB_ACK_OUT    = s_r.ack;
  assign TIMER_IRQ_OUT = s_r.irq;

  // edges come from the two-flop synchroniser, never the raw pin
  property p_ev_count;
    @(posedge CLK_SYS_IN) disable iff (!ARST_N_IN)
    (s_r.run && s_r.mode == PEC_MODE_EVENT && pin_rise && !wr_ctrl && !stop_sync_r)
      |=> s_r.cnt == $past(s_r.cnt) + CNT_W'(1);
  endproperty
  a_ev_count: assert property (p_ev_count) else $error("event count missed a rise");

  property p_ev_match_clear;
    @(posedge CLK_SYS_IN) disable iff (!ARST_N_IN)
    (ev_match && !wr_ctrl && !stop_sync_r) |=> (s_r.cnt == RST_CNT) ##1 s_r.irq == 1'b0;
  endproperty
  a_ev_match_clear: assert property (p_ev_match_clear) else $error("no clear on match");

  property p_ev_irq_on_fall;
    @(posedge CLK_SYS_IN) disable iff (!ARST_N_IN)
    $rose(s_r.irq) && $past(s_r.mode) == PEC_MODE_EVENT |-> $past(pin_fall);
  endproperty
  a_ev_irq_on_fall: assert property (p_ev_irq_on_fall) else $error("irq not at a fall");

  property p_autocap_copy;
    @(posedge CLK_SYS_IN) disable iff (!ARST_N_IN)
    (s_r.run && s_r.mode == PEC_MODE_EVENT && s_r.auto_capture_enable && !s_r.zero_hold)
      |=> s_r.reg_b == $past(s_r.cnt);
  endproperty
  a_autocap_copy: assert property (p_autocap_copy) else $error("auto-capture missed");

  property p_autocap_skip_zero;
    @(posedge CLK_SYS_IN) disable iff (!ARST_N_IN)
    (s_r.zero_hold && s_r.mode == PEC_MODE_EVENT) |=> $stable(s_r.reg_b);
  endproperty
  a_autocap_skip_zero: assert property (p_autocap_skip_zero)
    else $error("zero was captured");

  property p_cap_fall;
    @(posedge CLK_SYS_IN) disable iff (!ARST_N_IN)
    (s_r.run && s_r.mode == PEC_MODE_CAPTURE && !s_r.susp && pin_fall)
      |=> s_r.reg_b == $past(s_r.cnt);
  endproperty
  a_cap_fall: assert property (p_cap_fall) else $error("fall capture missed");

  property p_cap_rise;
    @(posedge CLK_SYS_IN) disable iff (!ARST_N_IN)
    (s_r.run && s_r.mode == PEC_MODE_CAPTURE && !s_r.susp && pin_rise && !wr_ctrl
     && !stop_sync_r) |=> s_r.irq && s_r.reg_a == $past(s_r.cnt) && s_r.cnt == RST_CNT
     && $stable(s_r.reg_b);
  endproperty
  a_cap_rise: assert property (p_cap_rise) else $error("rise capture wrong");

  property p_cap_ovf;
    @(posedge CLK_SYS_IN) disable iff (!ARST_N_IN)
    (cap_ovf && !wr_ctrl && !stop_sync_r)
      |=> s_r.irq && s_r.susp && s_r.reg_a == CNT_MAX && s_r.cnt == RST_CNT;
  endproperty
  a_cap_ovf: assert property (p_cap_ovf) else $error("overflow handling wrong");

  property p_susp_hold;
    @(posedge CLK_SYS_IN) disable iff (!ARST_N_IN)
    (s_r.susp && !rd_a && s_nxt.run) |=> s_r.susp && !s_r.irq;
  endproperty
  a_susp_hold: assert property (p_susp_hold) else $error("suspend dropped early");

  property p_stop_clears_run;
    @(posedge CLK_SYS_IN) disable iff (!ARST_N_IN)
    stop_sync_r |=> !s_r.run ##1 (s_r.cnt == RST_CNT || s_r.run);
  endproperty
  a_stop_clears_run: assert property (p_stop_clears_run) else $error("stop kept run");

  // several sources raise irq; none may stretch it past one cycle
  property p_irq_pulse;
    @(posedge CLK_SYS_IN) disable iff (!ARST_N_IN)
    s_r.irq |=> !s_r.irq;
  endproperty
  a_irq_pulse: assert property (p_irq_pulse) else $error("irq held too long");

  property p_cap_no_autocap;
    @(posedge CLK_SYS_IN) disable iff (!ARST_N_IN)
    (s_r.run && s_r.mode == PEC_MODE_CAPTURE && !pin_fall) |=> $stable(s_r.reg_b);
  endproperty
  a_cap_no_autocap: assert property (p_cap_no_autocap) else $error("reg b moved");

  property p_susp_frozen;
    @(posedge CLK_SYS_IN) disable iff (!ARST_N_IN)
    (s_r.run && s_r.mode == PEC_MODE_CAPTURE && s_r.susp && !wr_a)
      |=> $stable(s_r.reg_a) && $stable(s_r.reg_b);
  endproperty
  a_susp_frozen: assert property (p_susp_frozen) else $error("capture while suspended");

  property p_stopped_idle;
    @(posedge CLK_SYS_IN) disable iff (!ARST_N_IN)
    (!s_r.run && !wr_ctrl) |=> s_r.cnt == RST_CNT && !s_r.irq;
  endproperty
  a_stopped_idle: assert property (p_stopped_idle) else $error("stopped counter moved");

endmodule

/* File: dv/pec_pulse_src.sv */
// external pulse source model driving the event input pin
`timescale 1ns/1ps
module pec_pulse_src (
  input  wire logic clk_in,
  output logic      pin_out
);
  initial pin_out = 1'b0;
  // short phases are stretched: the pin passes a two-flop sync first
  task automatic level(input logic v, input int n);
    begin
      pin_out <= v;
      repeat ((n < 4) ? 4 : n) @(posedge clk_in);
    end
  endtask
endmodule

/* File: dv/tb_pec_top.sv */
// self-checking bench of the pulse event counter and capture unit
`timescale 1ns/1ps
module tb_pec_top;
  import pec_pkg::*;
  logic        clk    = 1'b0;
  logic        arst_n = 1'b0;
  logic        cyc    = 1'b0;
  logic        stb    = 1'b0;
  logic        we     = 1'b0;
  logic [7:0]  adr    = 8'h00;
  logic [3:0]  sel    = 4'h0;
  logic [31:0] wdat   = 32'h0;
  logic        stop   = 1'b0;
  logic [31:0] rdat;
  logic        ack;
  logic        pin;
  logic        irq;
  logic [31:0] q;
  int          miscompares = 0;
  int          comparisons = 0;
  int          irq_cnt     = 0;
  int          base;

  always #10 clk = ~clk;
  // counted mid-cycle so that a check at the next rising edge already sees it
  always @(negedge clk) if (irq === 1'b1) irq_cnt <= irq_cnt + 1;

  pec_pulse_src src_u (.clk_in(clk), .pin_out(pin));

  pec_top dut_u (
    .CLK_SYS_IN(clk), .ARST_N_IN(arst_n), .WB_CYC_IN(cyc), .WB_STB_IN(stb),
    .WB_WE_IN(we), .WB_ADR_IN(adr), .WB_SEL_IN(sel), .WB_DAT_IN(wdat),
    .WB_DAT_OUT(rdat), .WB_ACK_OUT(ack), .EVENT_INPUT_PIN_IN(pin),
    .STOP_ENTRY_IN(stop), .TIMER_IRQ_OUT(irq)
  );

  task automatic report_and_stop;
    begin
      $display("comparisons %0d miscompares %0d", comparisons, miscompares);
      if (miscompares == 0 && comparisons > 0) begin
        $display("NO MISMATCHES");
      end else begin
        $display("MISMATCHES SEEN");
      end
      $finish;
    end
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    begin
      comparisons++;
      if (seen !== exp) begin
        miscompares++;
        $display("BAD at %0t seen %h expected %h", $time, seen, exp);
      end
    end
  endtask

  // read data is taken at the edge that samples ack, then the request drops
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    begin
      n = 0;
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      sel <= 4'hf;
      wdat <= d;
      do begin
        @(posedge clk);
        n++;
      end while (ack !== 1'b1 && n < 20);
      q = rdat;
      cyc <= 1'b0;
      stb <= 1'b0;
      we <= 1'b0;
      @(posedge clk);
      if (n >= 20) begin
        miscompares++;
        report_and_stop();
      end
    end
  endtask

  task automatic rd(input logic [7:0] a);
    wb(1'b0, a, 32'h0);
  endtask

  task automatic t_reset;
    begin
      rd(OFS_CTRL);
      check(q, 32'h0);
      rd(OFS_REG_A);
      check(q, {24'h0, RST_REG_A});
      rd(OFS_REG_B);
      check(q, 32'h0000_00ff);
      rd(8'h10);
      check(q, 32'h0);
      $display("test reset done");
    end
  endtask

  // auto-capture enable set on purpose: capture mode must ignore it
  task automatic t_capture;
    begin
      base = irq_cnt;
      wb(1'b1, OFS_CTRL, 32'h07);
      src_u.level(1'b0, 20);
      src_u.level(1'b1, 4);
      rd(OFS_REG_B);
      check(q, 32'h0000_00ff);
      src_u.level(1'b1, 3);
      check(32'(irq_cnt - base), 32'h1);
      src_u.level(1'b0, 6);
      rd(OFS_REG_B);
      check({31'h0, q[7:0] >= 8'h09 && q[7:0] <= 8'h0b}, 32'h1);
      src_u.level(1'b0, 3);
      src_u.level(1'b1, 4);
      check(32'(irq_cnt - base), 32'h2);
      rd(OFS_REG_A);
      check({31'h0, q[7:0] >= 8'h15 && q[7:0] <= 8'h17}, 32'h1);
      src_u.level(1'b0, 4);
      $display("test capture done");
    end
  endtask

  task automatic t_overflow;
    begin
      wb(1'b1, OFS_CTRL, 32'h0);
      wb(1'b1, OFS_CTRL, 32'h13);
      base = irq_cnt;
      // source clock at half rate: no overflow yet after 300 cycles
      src_u.level(1'b0, 300);
      check(32'(irq_cnt - base), 32'h0);
      src_u.level(1'b0, 300);
      check(32'(irq_cnt - base), 32'h1);
      rd(OFS_STATUS);
      check({31'h0, q[STAT_SUSP_BIT]}, 32'h1);
      src_u.level(1'b1, 6);
      src_u.level(1'b0, 6);
      check(32'(irq_cnt - base), 32'h1);
      rd(OFS_REG_A);
      check(q, 32'h0000_00ff);
      rd(OFS_STATUS);
      check({31'h0, q[STAT_SUSP_BIT]}, 32'h0);
      src_u.level(1'b1, 6);
      check(32'(irq_cnt - base), 32'h2);
      src_u.level(1'b0, 6);
      $display("test overflow done");
    end
  endtask

  task automatic t_event;
    begin
      wb(1'b1, OFS_CTRL, 32'h0);
      wb(1'b1, OFS_REG_A, 32'h3);
      wb(1'b1, OFS_CTRL, 32'h05);
      base = irq_cnt;
      repeat (2) begin
        src_u.level(1'b1, 4);
        src_u.level(1'b0, 8);
      end
      rd(OFS_STATUS);
      check({24'h0, q[7:0]}, 32'h2);
      rd(OFS_REG_B);
      check(q, 32'h2);
      src_u.level(1'b1, 4);
      check(32'(irq_cnt - base), 32'h0);
      src_u.level(1'b0, 8);
      check(32'(irq_cnt - base), 32'h1);
      rd(OFS_STATUS);
      check({24'h0, q[7:0]}, 32'h0);
      check({31'h0, q[STAT_ZERO_BIT]}, 32'h1);
      rd(OFS_REG_B);
      check(q, 32'h3);
      src_u.level(1'b1, 4);
      src_u.level(1'b0, 8);
      rd(OFS_REG_B);
      check(q, 32'h1);
      $display("test event done");
    end
  endtask

  task automatic t_stop;
    begin
      stop <= 1'b1;
      repeat (4) @(posedge clk);
      stop <= 1'b0;
      repeat (4) @(posedge clk);
      rd(OFS_CTRL);
      check({31'h0, q[CTRL_RUN_BIT]}, 32'h0);
      src_u.level(1'b1, 6);
      src_u.level(1'b0, 6);
      rd(OFS_STATUS);
      check({24'h0, q[7:0]}, 32'h0);
      $display("test stop done");
    end
  endtask

  initial begin
    repeat (16) @(posedge clk);
    arst_n <= 1'b1;
    @(posedge clk);
    t_reset();
    t_capture();
    t_overflow();
    t_event();
    t_stop();
    report_and_stop();
  end
endmodule
